/* File: hlcf_flags.sv */
/*
 * Host controller control flag register with set/clear address pair,
 * delayed acknowledge, PHY-domain access guard and self-clearing soft reset.
 * Assumes host requests and received-packet notices arrive on ref_clk;
 * phy_clk_running is an asynchronous level from the PHY clock domain.
 */
module hlcf_flags
    import hlcf_pkg::*;
#(
    parameter int SOFT_CYC = SOFT_RST_CYC
) (
    input  wire logic      ref_clk,
    input  wire logic      rst,
    input  wire hlcf_req_s bus_req,
    output hlcf_rsp_s      bus_rsp,
    input  wire logic      abort_suppress,
    input  wire logic      phy_clk_running,
    input  wire logic      eeprom_valid,
    input  wire logic      eeprom_permission,
    input  wire hlcf_rx_s  rx_pkt,
    output logic           rx_accept,
    output logic           ack_tardy_send,
    output logic           ack_tardy_event,
    output logic           delayed_ack_enable,
    output logic           phy_enhance_permission,
    output logic           phy_enhance_enable,
    output logic           link_power_status,
    output logic           posted_write_enable_a,
    output logic           link_enable_b,
    output logic           soft_reset_c,
    output logic           fifo_flush
);

    // Soft reset counter is 8 bits wide
    if (SOFT_CYC < 1 || SOFT_CYC > 255) begin : g_soft_cyc_chk
        $error("SOFT_CYC out of range");
    end

    // ==========================================================
    // Decode
    logic [31:0] flags;
    logic        perm;
    logic        soft_busy;
    logic [7:0]  soft_cnt;
    logic        phy_run_m;
    logic        phy_run_s;
    logic        hit_set;
    logic        hit_clr;
    logic        phy_dom;
    logic        wr_ok;
    logic [31:0] rd_val;

    assign hit_set = bus_req.valid && bus_req.addr == OFS_SET;
    assign hit_clr = bus_req.valid && bus_req.addr == OFS_CLR;
    assign phy_dom = (bus_req.addr >= PHY_LO1 && bus_req.addr <= PHY_HI1)
                  || (bus_req.addr >= PHY_LO2 && bus_req.addr <= PHY_HI2);
    assign wr_ok   = bus_req.write && !soft_busy;
    // Reserved bits masked off; permission and busy merged in
    assign rd_val  = (flags & IMPL_MASK)
                   | ({31'h0000_0000, perm} << BIT_PERMISSION)
                   | ({31'h0000_0000, soft_busy} << BIT_SOFT);

    // ==========================================================
    // PHY clock presence synchroniser
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phy_run_m <= 1'b0;
            phy_run_s <= 1'b0;
        end else begin
            phy_run_m <= phy_clk_running;
            phy_run_s <= phy_run_m;
        end
    end

    // ==========================================================
    // Flag bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags <= FLAGS_RESET & SET_MASK;
        end else if (soft_busy) begin
            flags <= FLAGS_RESET & SET_MASK;
        end else if (hit_set && wr_ok) begin
            flags <= flags | (bus_req.wdata & SET_MASK & ~(32'h1 << BIT_SOFT));
        end else if (hit_clr && wr_ok) begin
            flags <= flags & ~(bus_req.wdata & CLR_MASK);
        end
    end

    // Permission survives soft reset; only hard reset and the EEPROM load change it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            perm <= PERM_RESET;
        end else if (eeprom_valid) begin
            perm <= eeprom_permission;
        end
    end

    // ==========================================================
    // Soft reset sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            soft_busy <= 1'b0;
            soft_cnt  <= 8'h00;
        end else if (soft_busy) begin
            soft_cnt <= soft_cnt - 8'h01;
            if (soft_cnt == 8'h01)
                soft_busy <= 1'b0;
        end else if (hit_set && bus_req.write && bus_req.wdata[BIT_SOFT]) begin
            soft_busy <= 1'b1;
            soft_cnt  <= 8'(SOFT_CYC);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst)
            fifo_flush <= 1'b1;
        else
            fifo_flush <= soft_busy;
    end

    // ==========================================================
    // Host bus answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_rsp <= '0;
        end else begin
            bus_rsp <= '0;
            if (bus_req.valid) begin
                bus_rsp.valid <= 1'b1;
                if (hit_set || hit_clr) begin
                    bus_rsp.rdata <= bus_req.write ? 32'h0000_0000 : rd_val;
                end else if (phy_dom && !phy_run_s) begin
                    if (abort_suppress)
                        bus_rsp.rdata <= bus_req.write ? 32'h0000_0000
                                                       : ALL_ONES;
                    else
                        bus_rsp.abort <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Packet side
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_accept       <= 1'b0;
            ack_tardy_send  <= 1'b0;
            ack_tardy_event <= 1'b0;
        end else begin
            rx_accept       <= rx_pkt.valid && link_enable_b;
            ack_tardy_send  <= rx_pkt.valid && rx_pkt.own_async
                            && link_enable_b && delayed_ack_enable;
            ack_tardy_event <= rx_pkt.valid && rx_pkt.own_async
                            && link_enable_b && delayed_ack_enable;
        end
    end

    assign delayed_ack_enable     = flags[BIT_DELAYED_ACK];
    assign phy_enhance_permission = perm;
    assign phy_enhance_enable     = flags[BIT_ENHANCE];
    assign link_power_status      = flags[BIT_LPS];
    assign posted_write_enable_a  = flags[BIT_POSTED];
    assign link_enable_b          = flags[BIT_LINK];
    assign soft_reset_c           = soft_busy;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic last_flag_rd;
    always_ff @(posedge ref_clk) begin
        if (rst)
            last_flag_rd <= 1'b0;
        else
            last_flag_rd <= (hit_set || hit_clr) && !bus_req.write;
    end

    reserved_zero_a: assert property (
        bus_rsp.valid && last_flag_rd |-> (bus_rsp.rdata & ~IMPL_MASK) == 0)
        else $error("reserved bits read nonzero");
    set_link_a: assert property (
        hit_set && wr_ok && bus_req.wdata[BIT_LINK] |=> link_enable_b)
        else $error("set address failed to set link enable");
    clear_lps_a: assert property (
        hit_clr && wr_ok && bus_req.wdata[BIT_LPS] |=> !link_power_status)
        else $error("clear address failed to clear power status");
    zero_keep_a: assert property (
        hit_set && wr_ok && !bus_req.wdata[BIT_LPS]
        |=> link_power_status == $past(link_power_status))
        else $error("zero bit changed a flag");
    tardy_ack_a: assert property (
        rx_pkt.valid && rx_pkt.own_async && link_enable_b
        && delayed_ack_enable |=> ack_tardy_send && ack_tardy_event)
        else $error("ack_tardy or its event missing");
    link_off_a: assert property (
        !link_enable_b |=> !rx_accept && !ack_tardy_send)
        else $error("packet handled while link disabled");
    phy_abort_a: assert property (
        bus_req.valid && phy_dom && !phy_run_s && !abort_suppress
        |=> bus_rsp.valid && bus_rsp.abort)
        else $error("no abort for stopped PHY clock");
    phy_ones_a: assert property (
        bus_req.valid && !bus_req.write && phy_dom && !phy_run_s
        && abort_suppress |=> !bus_rsp.abort && bus_rsp.rdata == ALL_ONES)
        else $error("suppressed access did not read all ones");
    soft_seq_a: assert property (
        hit_set && bus_req.write && bus_req.wdata[BIT_SOFT] && !soft_busy
        |=> soft_reset_c ##1 !link_enable_b ##[0:300] !soft_reset_c)
        else $error("soft reset did not run and self-clear");
    perm_load_a: assert property (
        eeprom_valid |=> phy_enhance_permission == $past(eeprom_permission))
        else $error("permission not loaded");

    soft_run_c: cover property ($fell(soft_reset_c));
    tardy_c: cover property (ack_tardy_send);
    abort_c: cover property (bus_rsp.abort);

endmodule

/* File: hlcf_flags_test.sv */
/*
 * Self-checking testbench for the host controller control flag register.
 * Assumes hlcf_pkg and hlcf_flags are compiled first; the bench drives
 * every port itself and shortens the soft reset to SOFT_N cycles.
 */
module hlcf_flags_test
    import hlcf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals and instance
    localparam int SOFT_N = 4;
    logic      ref_clk;
    logic      rst;
    hlcf_req_s bus_req;
    hlcf_rsp_s bus_rsp;
    logic      abort_suppress;
    logic      phy_clk_running;
    logic      eeprom_valid;
    logic      eeprom_permission;
    hlcf_rx_s  rx_pkt;
    logic      rx_accept;
    logic      ack_tardy_send;
    logic      ack_tardy_event;
    wire [5:0]  flag_bits;
    logic      soft_reset_c;
    logic      fifo_flush;
    int        err_count;
    int        comparisons;
    hlcf_rsp_s r;
    logic [11:0] phy_addr [8] = '{12'h0dc, 12'h0f0, 12'h100, 12'h11c,
                                  12'h0d8, 12'h0f4, 12'h0fc, 12'h120};

    hlcf_flags #(.SOFT_CYC(SOFT_N)) uut (
        .ref_clk               (ref_clk),
        .rst                   (rst),
        .bus_req               (bus_req),
        .bus_rsp               (bus_rsp),
        .abort_suppress        (abort_suppress),
        .phy_clk_running       (phy_clk_running),
        .eeprom_valid          (eeprom_valid),
        .eeprom_permission     (eeprom_permission),
        .rx_pkt                (rx_pkt),
        .rx_accept             (rx_accept),
        .ack_tardy_send        (ack_tardy_send),
        .ack_tardy_event       (ack_tardy_event),
        .delayed_ack_enable    (flag_bits[5]),
        .phy_enhance_permission(flag_bits[4]),
        .phy_enhance_enable    (flag_bits[3]),
        .link_power_status     (flag_bits[2]),
        .posted_write_enable_a (flag_bits[1]),
        .link_enable_b         (flag_bits[0]),
        .soft_reset_c          (soft_reset_c),
        .fifo_flush            (fifo_flush)
    );

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output hlcf_rsp_s rsp);
        @(posedge ref_clk);
        #1;
        bus_req = '{1'b1, wr, a, d};
        @(posedge ref_clk);
        #1;
        bus_req.valid = 1'b0;
        rsp = bus_rsp;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, r);
        chk(r.valid, 1'b1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000, r);
        chk({r.valid, r.abort}, 2'h2);
        chk(r.rdata, exp);
    endtask

    task automatic pk(input logic own, input logic [2:0] exp);
        @(posedge ref_clk);
        #1;
        rx_pkt = '{1'b1, own};
        @(posedge ref_clk);
        #1;
        rx_pkt.valid = 1'b0;
        chk({rx_accept, ack_tardy_send, ack_tardy_event}, exp);
    endtask

    task automatic summarize;
        if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #200us;
        err_count++;
        summarize();
    end

    initial begin
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        bus_req = '0;
        rx_pkt = '0;
        abort_suppress = 1'b0;
        phy_clk_running = 1'b1;
        eeprom_valid = 1'b0;
        eeprom_permission = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        chk(fifo_flush, 1'b1);
        rst = 1'b0;
        rd(OFS_SET, FLAGS_RESET);
        pk(1'b1, 3'h0);
        wr(OFS_SET, 32'hfffe_ffff);
        chk(flag_bits, 6'h3f);
        rd(OFS_CLR, 32'h20ce_0000);
        pk(1'b1, 3'h7);
        pk(1'b0, 3'h4);
        wr(OFS_CLR, 32'h0000_0000);
        rd(OFS_SET, 32'h20ce_0000);
        wr(OFS_CLR, 32'h0088_0000);
        rd(OFS_SET, 32'h20c6_0000);
        wr(OFS_CLR, 32'h2000_0000);
        pk(1'b1, 3'h4);
        wr(OFS_CLR, 32'h0002_0000);
        pk(1'b1, 3'h0);
        wr(OFS_SET, 32'h0003_0000);
        chk(soft_reset_c, 1'b1);
        rd(OFS_CLR, 32'h0081_0000);
        chk(fifo_flush, 1'b1);
        for (int i = 0; i < 50 && soft_reset_c === 1'b1; i++)
            @(posedge ref_clk);
        #1;
        chk(soft_reset_c, 1'b0);
        rd(OFS_SET, FLAGS_RESET);
        phy_clk_running = 1'b0;
        repeat (4) @(posedge ref_clk);
        foreach (phy_addr[i]) begin
            acc(1'b0, phy_addr[i], 32'h0000_0000, r);
            chk({r.valid, r.abort}, {1'b1, i < 4});
        end
        abort_suppress = 1'b1;
        foreach (phy_addr[i]) begin
            acc(1'b0, phy_addr[i], 32'h0000_0000, r);
            chk({r.valid, r.abort}, 2'h2);
            chk(r.rdata, (i < 4) ? ALL_ONES : 32'h0000_0000);
        end
        phy_clk_running = 1'b1;
        abort_suppress = 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(PHY_LO1, 32'h0000_0000);
        @(posedge ref_clk);
        #1;
        eeprom_permission = 1'b0;
        eeprom_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        eeprom_valid = 1'b0;
        wr(OFS_SET, 32'h0080_0000);
        rd(OFS_SET, 32'h0000_0000);
        summarize();
    end
endmodule

/* File: hlcf_pkg.sv */
/*
 * Constants and carrier types for the host controller control flags.
 * Assumes a 100 MHz ref_clk and a 12-bit link register address space.
 */
package hlcf_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [11:0] OFS_SET     = 12'h050;
    localparam logic [11:0] OFS_CLR     = 12'h054;
    localparam logic [11:0] PHY_LO1     = 12'h0dc;
    localparam logic [11:0] PHY_HI1     = 12'h0f0;
    localparam logic [11:0] PHY_LO2     = 12'h100;
    localparam logic [11:0] PHY_HI2     = 12'h11c;

    // ==========================================================
    // Field positions
    localparam int BIT_DELAYED_ACK = 29;
    localparam int BIT_PERMISSION  = 23;
    localparam int BIT_ENHANCE     = 22;
    localparam int BIT_LPS         = 19;
    localparam int BIT_POSTED      = 18;
    localparam int BIT_LINK        = 17;
    localparam int BIT_SOFT        = 16;

    // ==========================================================
    // Reset values and masks
    localparam logic [31:0] FLAGS_RESET = 32'h0080_0000;
    localparam logic [31:0] SET_MASK    = 32'h204f_0000;
    localparam logic [31:0] CLR_MASK    = 32'h204e_0000;
    localparam logic [31:0] IMPL_MASK   = 32'h20cf_0000;
    localparam logic [31:0] ALL_ONES    = 32'hffff_ffff;
    localparam logic        PERM_RESET  = 1'h1;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RST_NS   = 200;
    localparam int SOFT_RST_CYC  =
        (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } hlcf_req_s;

    typedef struct packed {
        logic        valid;
        logic        abort;
        logic [31:0] rdata;
    } hlcf_rsp_s;

    typedef struct packed {
        logic valid;
        logic own_async;
    } hlcf_rx_s;

endpackage
